// ==== timer_defs.vh ====
// Register map, field positions and reset values of the timer block.
// Assumes an 8-bit register port with 16-bit addresses.
`ifndef TIMER_DEFS_VH
`define TIMER_DEFS_VH

// ****************************************************************
// Register addresses
// ****************************************************************
`define ADDR_WD_RUN_CONTROL  16'ha0a0
`define ADDR_GP_RUN_CONTROL  16'ha0a1
`define ADDR_TIMEOUT_FLAGS   16'ha0a2
`define ADDR_GP_LIMIT        16'ha0a3
`define ADDR_WD_LIMIT        16'ha0a4
`define ADDR_TICK_SELECT     16'ha0a5
`define ADDR_IRQ_MASK        16'ha0a6

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_COUNT_ENABLE     0
`define BIT_WD_KICK          4
`define BIT_GP_FLAG          0
`define BIT_WD_FLAG          4
`define BIT_GP_IRQ_ENABLE    0
`define BIT_WD_IRQ_ENABLE    4
`define GP_TICK_LSB          0
`define WD_TICK_LSB          4

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_LIMIT            8'hff
`define RST_TICK_SELECT      2'h0

// ****************************************************************
// Time base: reference rate and derived tick rates in Hz, plus seconds per minute
// ****************************************************************
`define REF_HZ               32768
`define RATE_FAST_HZ         1024
`define RATE_WD_FAST_HZ      8
`define SECONDS_PER_MINUTE   60

`endif

// ==== timer_regs.v ====
// General-purpose timer and watchdog timer with their register set.
// Assumes a synchronous 8-bit register port on core_clk and a free
// running 32.768 kHz reference level arriving from another domain.
`timescale 1ns/1ns
`include "timer_defs.vh"

module timer_regs
#(
    parameter WIDTH = 8
)
(
    input  wire             core_clk,
    input  wire             sys_rst,
    input  wire             ref_clk_32k,
    input  wire [15:0]      reg_addr,
    input  wire             reg_wr,
    input  wire             reg_rd,
    input  wire [7:0]       reg_wdata,
    output reg  [7:0]       reg_rdata,
    output reg              timer_irq
);

    // ****************************************************************
    // Reference synchroniser and tick generation
    // ****************************************************************
    localparam integer PRESC_LAST_N = `REF_HZ - 1;
    localparam integer FAST_LAST_N  = (`REF_HZ / `RATE_FAST_HZ) - 1;
    localparam integer WDF_LAST_N   = (`REF_HZ / `RATE_WD_FAST_HZ) - 1;
    localparam integer MIN_LAST_N   = `SECONDS_PER_MINUTE - 1;
    localparam [14:0] PRESC_LAST = PRESC_LAST_N[14:0];
    localparam [4:0]  FAST_LAST  = FAST_LAST_N[4:0];
    localparam [11:0] WDF_LAST   = WDF_LAST_N[11:0];
    localparam [5:0]  MIN_LAST   = MIN_LAST_N[5:0];

    reg                 ref_meta;
    reg                 ref_sync;
    reg                 ref_prev;
    reg  [14:0]         presc;
    reg                 half_hz;
    reg  [5:0]          seconds;
    wire                ref_tick;
    wire                tick_fast;
    wire                tick_wd_fast;
    wire                tick_sec;
    wire                tick_half;
    wire                tick_min;

    // Two flops before any logic looks at the reference
    always @(posedge core_clk)
    begin
        ref_meta <= ref_clk_32k;
        ref_sync <= ref_meta;
        ref_prev <= ref_sync;
    end

    assign ref_tick     = ref_sync & ~ref_prev;
    assign tick_fast    = ref_tick && (presc[4:0] == FAST_LAST);
    assign tick_wd_fast = ref_tick && (presc[11:0] == WDF_LAST);
    assign tick_sec     = ref_tick && (presc == PRESC_LAST);
    assign tick_half    = tick_sec && half_hz;
    assign tick_min     = tick_sec && (seconds == MIN_LAST);

    // One prescaler chain serves every rate, so all ticks stay aligned
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            presc   <= 15'h0000;
            half_hz <= 1'b0;
            seconds <= 6'h00;
        end
        else if (ref_tick)
        begin
            presc <= presc + 15'h0001;
            if (tick_sec)
            begin
                half_hz <= ~half_hz;
                seconds <= (seconds == MIN_LAST) ? 6'h00 : seconds + 6'h01;
            end
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg                 gp_count_enable;
    reg                 wd_count_enable;
    reg                 gp_timeout_flag;
    reg                 wd_timeout_flag;
    reg  [WIDTH-1:0]    gp_timeout_value;
    reg  [WIDTH-1:0]    wd_timeout_value;
    reg  [1:0]          gp_tick_select;
    reg  [1:0]          wd_tick_select;
    reg                 gp_irq_enable;
    reg                 wd_irq_enable;
    reg  [WIDTH-1:0]    gp_count;
    reg  [WIDTH-1:0]    wd_count;
    reg                 gp_tick;
    reg                 wd_tick;
    wire                wr_gp_run;
    wire                wr_wd_run;
    wire                wr_flags;
    wire                wd_kick;
    wire                gp_timeout;
    wire                wd_timeout;

    assign wr_gp_run = reg_wr && (reg_addr == `ADDR_GP_RUN_CONTROL);
    assign wr_wd_run = reg_wr && (reg_addr == `ADDR_WD_RUN_CONTROL);
    assign wr_flags  = reg_wr && (reg_addr == `ADDR_TIMEOUT_FLAGS);
    assign wd_kick   = wr_wd_run && reg_wdata[`BIT_WD_KICK];

    // Time base decode per timer
    always @*
    begin
        case (gp_tick_select)
            2'b00:   gp_tick = ref_tick;
            2'b01:   gp_tick = tick_fast;
            2'b10:   gp_tick = tick_sec;
            default: gp_tick = tick_min;
        endcase
        case (wd_tick_select)
            2'b00:   wd_tick = tick_wd_fast;
            2'b01:   wd_tick = tick_sec;
            2'b10:   wd_tick = tick_half;
            default: wd_tick = tick_min;
        endcase
    end

    // Timeout when the running count meets its limit; a kick in the same cycle holds off the watchdog timeout
    assign gp_timeout = gp_count_enable && (gp_count == gp_timeout_value);
    assign wd_timeout = wd_count_enable && (wd_count == wd_timeout_value) && !wd_kick;

    // Plain settings; reserved addresses take no effect when written
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            gp_timeout_value <= `RST_LIMIT;
            wd_timeout_value <= `RST_LIMIT;
            gp_tick_select   <= `RST_TICK_SELECT;
            wd_tick_select   <= `RST_TICK_SELECT;
            gp_irq_enable    <= 1'b0;
            wd_irq_enable    <= 1'b0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `ADDR_GP_LIMIT)
                gp_timeout_value <= reg_wdata;
            else if (reg_addr == `ADDR_WD_LIMIT)
                wd_timeout_value <= reg_wdata;
            else if (reg_addr == `ADDR_TICK_SELECT)
            begin
                gp_tick_select <= reg_wdata[`GP_TICK_LSB+1:`GP_TICK_LSB];
                wd_tick_select <= reg_wdata[`WD_TICK_LSB+1:`WD_TICK_LSB];
            end
            else if (reg_addr == `ADDR_IRQ_MASK)
            begin
                gp_irq_enable <= reg_wdata[`BIT_GP_IRQ_ENABLE];
                wd_irq_enable <= reg_wdata[`BIT_WD_IRQ_ENABLE];
            end
        end
    end

    // ****************************************************************
    // General-purpose timer
    // ****************************************************************
    // Timeout beats a same-cycle enable write so the flag and stop agree
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            gp_count_enable <= 1'b0;
            gp_count        <= {WIDTH{1'b0}};
        end
        else if (gp_timeout)
        begin
            gp_count_enable <= 1'b0;
            gp_count        <= {WIDTH{1'b0}};
        end
        else
        begin
            if (wr_gp_run)
                gp_count_enable <= reg_wdata[`BIT_COUNT_ENABLE];
            if (!gp_count_enable || (wr_gp_run && !reg_wdata[`BIT_COUNT_ENABLE]))
                gp_count <= {WIDTH{1'b0}};
            else if (gp_tick)
                gp_count <= gp_count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // ****************************************************************
    // Watchdog timer
    // ****************************************************************
    // A kick zeroes the count; its write also loads the enable from bit 0
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            wd_count_enable <= 1'b0;
            wd_count        <= {WIDTH{1'b0}};
        end
        else if (wd_timeout)
        begin
            wd_count_enable <= 1'b0;
            wd_count        <= {WIDTH{1'b0}};
        end
        else
        begin
            if (wr_wd_run)
                wd_count_enable <= reg_wdata[`BIT_COUNT_ENABLE];
            if (!wd_count_enable || wd_kick || (wr_wd_run && !reg_wdata[`BIT_COUNT_ENABLE]))
                wd_count <= {WIDTH{1'b0}};
            else if (wd_tick)
                wd_count <= wd_count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // ****************************************************************
    // Timeout flags and interrupt
    // ****************************************************************
    // A timeout in the clearing cycle wins, so no event is lost
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            gp_timeout_flag <= 1'b0;
            wd_timeout_flag <= 1'b0;
        end
        else
        begin
            if (gp_timeout)
                gp_timeout_flag <= 1'b1;
            else if (wr_flags && reg_wdata[`BIT_GP_FLAG])
                gp_timeout_flag <= 1'b0;
            if (wd_timeout)
                wd_timeout_flag <= 1'b1;
            else if (wr_flags && reg_wdata[`BIT_WD_FLAG])
                wd_timeout_flag <= 1'b0;
        end
    end

    // Level interrupt, follows the flags one cycle later
    always @(posedge core_clk)
    begin
        if (sys_rst)
            timer_irq <= 1'b0;
        else
            timer_irq <= (gp_timeout_flag & gp_irq_enable) |
                         (wd_timeout_flag & wd_irq_enable);
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    // Reserved bits and unmapped addresses read as zero
    always @(posedge core_clk)
    begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            if (reg_addr == `ADDR_WD_RUN_CONTROL)
                reg_rdata <= {7'h00, wd_count_enable};
            else if (reg_addr == `ADDR_GP_RUN_CONTROL)
                reg_rdata <= {7'h00, gp_count_enable};
            else if (reg_addr == `ADDR_TIMEOUT_FLAGS)
                reg_rdata <= {3'h0, wd_timeout_flag, 3'h0, gp_timeout_flag};
            else if (reg_addr == `ADDR_GP_LIMIT)
                reg_rdata <= gp_timeout_value;
            else if (reg_addr == `ADDR_WD_LIMIT)
                reg_rdata <= wd_timeout_value;
            else if (reg_addr == `ADDR_TICK_SELECT)
                reg_rdata <= {2'h0, wd_tick_select, 2'h0, gp_tick_select};
            else if (reg_addr == `ADDR_IRQ_MASK)
                reg_rdata <= {3'h0, wd_irq_enable, 3'h0, gp_irq_enable};
            else
                reg_rdata <= 8'h00;
        end
    end

endmodule

// ==== timer_regs_props.sv ====
// Port-level checker for the timer register block.
// Assumes one core_clk domain and a synchronous active-high sys_rst.
`timescale 1ns/1ns
module timer_regs_props
(
    input logic        core_clk,
    input logic        sys_rst,
    input logic [15:0] reg_addr,
    input logic        reg_wr,
    input logic        reg_rd,
    input logic [7:0]  reg_wdata,
    input logic [7:0]  reg_rdata,
    input logic        timer_irq
);
    // ****************************************************************
    // Register port and interrupt properties
    // ****************************************************************
    // All checks share the core clock and are muted in reset
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (reg_rd && (reg_addr < 16'ha0a0 || reg_addr > 16'ha0a6)
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_kick_reads_zero: assert property (reg_rd && reg_addr == 16'ha0a0
        |=> reg_rdata[7:1] == 7'h00) else $error("kick or reserved bit read high");
    a_gp_ctrl_bits: assert property (reg_rd && reg_addr == 16'ha0a1
        |=> reg_rdata[7:1] == 7'h00) else $error("gp control reserved bits high");
    a_flag_bits: assert property (reg_rd && reg_addr == 16'ha0a2
        |=> (reg_rdata & 8'hee) == 8'h00) else $error("status reserved bits high");
    // Limit written, one idle cycle, then read back unchanged
    a_limit_readback: assert property ((reg_wr && (reg_addr == 16'ha0a3 || reg_addr == 16'ha0a4))
        ##1 !reg_wr ##1 (reg_rd && !reg_wr && reg_addr == $past(reg_addr, 2))
        |=> reg_rdata == $past(reg_wdata, 3)) else $error("limit readback wrong");
    a_irq_idle_reset: assert property ($fell(sys_rst) |-> !timer_irq)
        else $error("interrupt high right after reset");
    a_mask_clear_irq: assert property (reg_wr && reg_addr == 16'ha0a6 && reg_wdata == 8'h00
        |=> ##1 !timer_irq) else $error("interrupt outlived its mask");
endmodule

bind timer_regs timer_regs_props i_props (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .timer_irq(timer_irq));

// ==== timer_regs_tb.sv ====
// Self-checking testbench for the timer register block.
// Assumes the byte register port and a fast stand-in reference clock.
`timescale 1ns/1ns
module timer_regs_tb;
    reg         core_clk = 1'b0;
    reg         sys_rst = 1'b1;
    reg         ref_clk_32k = 1'b0;
    reg  [15:0] reg_addr = 16'h0000;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg  [7:0]  reg_wdata = 8'h00;
    wire [7:0]  reg_rdata;
    wire        timer_irq;
    integer     n_mismatch = 0;
    integer     comparisons = 0;
    integer     i;

    // ****************************************************************
    // Clocks and design
    // ****************************************************************
    // Reference far faster than real so timeouts stay short
    always #2 core_clk = ~core_clk;
    always #16 ref_clk_32k = ~ref_clk_32k;

    timer_regs i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .ref_clk_32k(ref_clk_32k),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .timer_irq(timer_irq));

    // ****************************************************************
    // Access and check tasks
    // ****************************************************************
    task check(input [7:0] seen, input [7:0] expect_val);
        begin
            comparisons = comparisons + 1;
            if (seen !== expect_val)
            begin
                n_mismatch = n_mismatch + 1;
                $display("BAD t=%0t seen %h expected %h", $time, seen, expect_val);
            end
        end
    endtask

    task write_reg(input [15:0] addr, input [7:0] data);
        begin
            @(posedge core_clk);
            #1;
            reg_addr = addr;
            reg_wdata = data;
            reg_wr = 1'b1;
            @(posedge core_clk);
            #1;
            reg_wr = 1'b0;
        end
    endtask

    // Data is checked just after the edge that takes the read strobe
    task read_reg(input [15:0] addr, input [7:0] expect_val);
        begin
            @(posedge core_clk);
            #1;
            reg_addr = addr;
            reg_rd = 1'b1;
            @(posedge core_clk);
            #1;
            reg_rd = 1'b0;
            check(reg_rdata, expect_val);
        end
    endtask

    // Bounded so a dead timer cannot hang the run
    task wait_cycles_irq(input integer limit);
        integer k;
        begin
            k = 0;
            while (timer_irq !== 1'b1 && k < limit)
            begin
                @(posedge core_clk);
                #1;
                k = k + 1;
            end
        end
    endtask

    task tally_and_finish;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
            if (n_mismatch == 0 && comparisons > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial
    begin
        repeat (6) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        for (i = 0; i < 7; i = i + 1)
            read_reg(16'ha0a0 + i[15:0], (i == 3 || i == 4) ? 8'hff : 8'h00);
        $display("reset values done");
        write_reg(16'ha0a3, 8'h5a);
        read_reg(16'ha0a3, 8'h5a);
        write_reg(16'ha0a4, 8'ha5);
        read_reg(16'ha0a4, 8'ha5);
        write_reg(16'ha0a5, 8'hff);
        read_reg(16'ha0a5, 8'h33);
        write_reg(16'ha0a6, 8'hff);
        read_reg(16'ha0a6, 8'h11);
        write_reg(16'ha0a0, 8'hff);
        read_reg(16'ha0a0, 8'h01);
        write_reg(16'ha0a0, 8'h00);
        write_reg(16'ha0a6, 8'h00);
        write_reg(16'ha0a5, 8'h00);
        read_reg(16'ha0a7, 8'h00);
        read_reg(16'ha0af, 8'h00);
        read_reg(16'ha0a6, 8'h00);
        $display("access kinds done");
        write_reg(16'ha0a3, 8'h03);
        write_reg(16'ha0a6, 8'h01);
        write_reg(16'ha0a1, 8'h01);
        wait_cycles_irq(400);
        check({7'h00, timer_irq}, 8'h01);
        read_reg(16'ha0a2, 8'h01);
        read_reg(16'ha0a1, 8'h00);
        read_reg(16'ha0a3, 8'h03);
        write_reg(16'ha0a2, 8'h00);
        read_reg(16'ha0a2, 8'h01);
        write_reg(16'ha0a2, 8'h01);
        read_reg(16'ha0a2, 8'h00);
        check({7'h00, timer_irq}, 8'h00);
        $display("gp timeout done");
        write_reg(16'ha0a3, 8'hff);
        write_reg(16'ha0a1, 8'h01);
        repeat (40) @(posedge core_clk);
        write_reg(16'ha0a1, 8'h00);
        read_reg(16'ha0a1, 8'h00);
        repeat (2500) @(posedge core_clk);
        read_reg(16'ha0a2, 8'h00);
        $display("gp stop done");
        write_reg(16'ha0a3, 8'h02);
        write_reg(16'ha0a5, 8'h01);
        write_reg(16'ha0a1, 8'h01);
        repeat (200) @(posedge core_clk);
        check({7'h00, timer_irq}, 8'h00);
        wait_cycles_irq(1200);
        check({7'h00, timer_irq}, 8'h01);
        write_reg(16'ha0a2, 8'h01);
        $display("tick select done");
        write_reg(16'ha0a4, 8'h00);
        write_reg(16'ha0a6, 8'h10);
        write_reg(16'ha0a0, 8'h01);
        wait_cycles_irq(50);
        check({7'h00, timer_irq}, 8'h01);
        write_reg(16'ha0a6, 8'h00);
        read_reg(16'ha0a2, 8'h10);
        check({7'h00, timer_irq}, 8'h00);
        read_reg(16'ha0a0, 8'h00);
        write_reg(16'ha0a2, 8'h10);
        read_reg(16'ha0a2, 8'h00);
        $display("watchdog done");
        tally_and_finish;
    end

    // Whole run is near 3200 cycles; this allows several times that
    initial
    begin
        #100000;
        n_mismatch = n_mismatch + 1;
        tally_and_finish;
    end
endmodule
